// >>> rtl/vref_pkg.sv
// Package with register map, field layout and timing constants for vref_ctrl
package vref_pkg;

   // Word offsets on the register bus
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] TSTAT_OFFSET = 8'h04;

   // Control register layout
   localparam int REF_EN_BIT = 7;
   localparam int REF_RDY_BIT = 6;
   localparam int TEMP_EN_BIT = 5;
   localparam int TEMP_RNG_BIT = 4;
   localparam int CMP_GAIN_LSB = 2;
   localparam int ADC_GAIN_LSB = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_WR_MASK = 8'hbf;

   // Timing status register layout
   localparam int TS_OK_BIT = 0;
   localparam int TS_ON_TEMP_BIT = 1;
   localparam int TS_EARLY_BIT = 2;

   // Gain codes shared by both reference paths
   localparam logic [1:0] GAIN_OFF = 2'h0;
   localparam logic [1:0] GAIN_1X = 2'h1;
   localparam logic [1:0] GAIN_2X = 2'h2;
   localparam logic [1:0] GAIN_4X = 2'h3;

   // Default converter channel reserved for the indicator
   localparam logic [3:0] TEMP_CHAN_DEFAULT = 4'hd;

   // Timing: clock rate and waits in their own units
   localparam int CLK_FREQ_MHZ = 125;
   localparam int TEMP_WAIT_US = 200;
   localparam int TEMP_WAIT_CYC = TEMP_WAIT_US * CLK_FREQ_MHZ;
   localparam int STAB_TIME_US = 20;
   localparam int STAB_CYC = STAB_TIME_US * CLK_FREQ_MHZ;

   // Reference state, Gray coded along off, settling, ready
   typedef enum logic [1:0] {
      REF_OFF = 2'b00,
      REF_SETTLING = 2'b01,
      REF_READY = 2'b11
   } ref_state_type;

endpackage : vref_pkg

// >>> rtl/vref_ctrl.sv
// Voltage reference and temperature indicator control with Wishbone slave
`timescale 1ns/100ps
module vref_ctrl #(
   parameter int CNT_W = 16,
   parameter int STAB_CYCLES = vref_pkg::STAB_CYC,
   parameter int TEMP_WAIT_CYCLES = vref_pkg::TEMP_WAIT_CYC,
   parameter bit HAS_LDO = 1'b0,
   parameter logic [3:0] TEMP_CHANNEL = vref_pkg::TEMP_CHAN_DEFAULT
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Analog reference controls
   output logic ref_enable_o,
   output logic reference_ready_o,
   output logic temp_indicator_enable_o,
   output logic temp_high_range_o,
   output logic [1:0] cmp_dac_ref_gain_o,
   output logic cmp_dac_ref_on_o,
   output logic [1:0] converter_ref_gain_o,
   output logic converter_ref_on_o,
   // Converter multiplexer side
   input wire logic [3:0] adc_channel_i,
   input wire logic adc_conv_start_i,
   output logic temp_route_o,
   output logic temp_acq_ok_o
);

   // Bus state
   logic ack_r, ack_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   // Control register and decoded outputs
   logic [7:0] ctrl_r, ctrl_nxt;
   logic cmp_on_r, cmp_on_nxt;
   logic adc_on_r, adc_on_nxt;
   // Reference settling
   vref_pkg::ref_state_type state_r, state_nxt;
   logic [CNT_W-1:0] stab_cnt_r, stab_cnt_nxt;
   logic ready_r, ready_nxt;
   // Indicator acquisition timing
   logic on_temp_r, on_temp_nxt;
   logic [CNT_W-1:0] wait_cnt_r, wait_cnt_nxt;
   logic acq_ok_r, acq_ok_nxt;
   logic early_r, early_nxt;

   logic req, wr_commit, sel_ctrl, sel_tstat;
   logic on_temp, restart;
   logic [7:0] ctrl_rd;
   logic [31:0] tstat_rd;

   // Request decode; writes commit at the edge where ack is seen high
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_commit = req & wb_we_i & ack_r & wb_sel_i[0];
   always_comb begin
      sel_ctrl = 1'b0;
      sel_tstat = 1'b0;
      if (wb_adr_i == vref_pkg::CTRL_OFFSET) begin
         sel_ctrl = 1'b1;
      end else if (wb_adr_i == vref_pkg::TSTAT_OFFSET) begin
         sel_tstat = 1'b1;
      end
   end

   // Read views; ready is a live flag, not a stored bit
   always_comb begin
      ctrl_rd = ctrl_r;
      ctrl_rd[vref_pkg::REF_RDY_BIT] = ready_r;
      tstat_rd = 32'h0000_0000;
      tstat_rd[vref_pkg::TS_OK_BIT] = acq_ok_r;
      tstat_rd[vref_pkg::TS_ON_TEMP_BIT] = on_temp_r;
      tstat_rd[vref_pkg::TS_EARLY_BIT] = early_r;
   end

   // Bus next state: one ack per request, unmapped reads give zero
   always_comb begin
      ack_nxt = req & ~ack_r;
      rdata_nxt = rdata_r;
      if (req & ~ack_r) begin
         if (sel_ctrl) begin
            rdata_nxt = {24'h00_0000, ctrl_rd};
         end else if (sel_tstat) begin
            rdata_nxt = tstat_rd;
         end else begin
            rdata_nxt = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Control register; the ready bit position is never stored
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_commit & sel_ctrl) begin
         ctrl_nxt = wb_dat_i[7:0] & vref_pkg::CTRL_WR_MASK;
      end
      cmp_on_nxt = ctrl_nxt[vref_pkg::CMP_GAIN_LSB +: 2]
         != vref_pkg::GAIN_OFF;
      adc_on_nxt = ctrl_nxt[vref_pkg::ADC_GAIN_LSB +: 2]
         != vref_pkg::GAIN_OFF;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= vref_pkg::CTRL_RESET;
         cmp_on_r <= 1'b0;
         adc_on_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         cmp_on_r <= cmp_on_nxt;
         adc_on_r <= adc_on_nxt;
      end
   end

   // Settling sequence; disabling at any point drops back to off
   always_comb begin
      state_nxt = state_r;
      stab_cnt_nxt = stab_cnt_r;
      case (state_r)
         vref_pkg::REF_OFF: begin
            stab_cnt_nxt = '0;
            if (ctrl_r[vref_pkg::REF_EN_BIT]) begin
               state_nxt = vref_pkg::REF_SETTLING;
            end
         end
         vref_pkg::REF_SETTLING: begin
            stab_cnt_nxt = stab_cnt_r + CNT_W'(1);
            if (stab_cnt_r >= CNT_W'(STAB_CYCLES - 1)) begin
               state_nxt = vref_pkg::REF_READY;
            end
         end
         vref_pkg::REF_READY: begin
            state_nxt = vref_pkg::REF_READY;
         end
         default: begin
            state_nxt = vref_pkg::REF_OFF;
         end
      endcase
      if (!ctrl_r[vref_pkg::REF_EN_BIT]) begin
         state_nxt = vref_pkg::REF_OFF;
      end
      // Regulator parts report ready unconditionally
      if (HAS_LDO) begin
         ready_nxt = 1'b1;
      end else begin
         ready_nxt = state_nxt == vref_pkg::REF_READY;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= vref_pkg::REF_OFF;
         stab_cnt_r <= '0;
         ready_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         stab_cnt_r <= stab_cnt_nxt;
         ready_r <= ready_nxt;
      end
   end

   // Indicator channel watch; channel select is same-clock logic
   assign on_temp = ctrl_r[vref_pkg::TEMP_EN_BIT]
      & (adc_channel_i == TEMP_CHANNEL);
   // A fresh selection or any conversion restarts the wait
   assign restart = on_temp & (~on_temp_r | adc_conv_start_i);

   always_comb begin
      on_temp_nxt = on_temp;
      wait_cnt_nxt = wait_cnt_r;
      if (restart | ~on_temp) begin
         wait_cnt_nxt = '0;
      end else if (wait_cnt_r < CNT_W'(TEMP_WAIT_CYCLES)) begin
         wait_cnt_nxt = wait_cnt_r + CNT_W'(1);
      end
      acq_ok_nxt = on_temp & ~restart
         & (wait_cnt_nxt >= CNT_W'(TEMP_WAIT_CYCLES));
      // Early start is sticky; a new event beats a software clear
      early_nxt = early_r;
      if (wr_commit & sel_tstat & wb_dat_i[vref_pkg::TS_EARLY_BIT]) begin
         early_nxt = 1'b0;
      end
      if (adc_conv_start_i & on_temp & ~acq_ok_r) begin
         early_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         on_temp_r <= 1'b0;
         wait_cnt_r <= '0;
         acq_ok_r <= 1'b0;
         early_r <= 1'b0;
      end else begin
         on_temp_r <= on_temp_nxt;
         wait_cnt_r <= wait_cnt_nxt;
         acq_ok_r <= acq_ok_nxt;
         early_r <= early_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdata_r;
   assign ref_enable_o = ctrl_r[vref_pkg::REF_EN_BIT];
   assign reference_ready_o = ready_r;
   assign temp_indicator_enable_o = ctrl_r[vref_pkg::TEMP_EN_BIT];
   assign temp_high_range_o = ctrl_r[vref_pkg::TEMP_RNG_BIT];
   // Code 11 on the comparator path is taken as 4x, like the converter
   assign cmp_dac_ref_gain_o = ctrl_r[vref_pkg::CMP_GAIN_LSB +: 2];
   assign cmp_dac_ref_on_o = cmp_on_r;
   assign converter_ref_gain_o = ctrl_r[vref_pkg::ADC_GAIN_LSB +: 2];
   assign converter_ref_on_o = adc_on_r;
   assign temp_route_o = on_temp_r;
   assign temp_acq_ok_o = acq_ok_r;

endmodule : vref_ctrl

// >>> verification/vref_ctrl_sva.sv
// Checker for the voltage reference control block ports
`timescale 1ns/100ps
module vref_ctrl_sva #(
   parameter logic [3:0] TEMP_CHANNEL = 4'hd
) (
   // Clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   // Reference and indicator outputs
   input wire logic ref_enable_o,
   input wire logic reference_ready_o,
   input wire logic temp_indicator_enable_o,
   input wire logic temp_high_range_o,
   input wire logic [1:0] cmp_dac_ref_gain_o,
   input wire logic cmp_dac_ref_on_o,
   input wire logic [1:0] converter_ref_gain_o,
   input wire logic converter_ref_on_o,
   // Converter side
   input wire logic [3:0] adc_channel_i,
   input wire logic adc_conv_start_i,
   input wire logic temp_route_o,
   input wire logic temp_acq_ok_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack wide");
   ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack");
   field_write_a: assert property (
      wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0] |=>
      {temp_indicator_enable_o, temp_high_range_o, cmp_dac_ref_gain_o,
      converter_ref_gain_o} == $past(wb_dat_i[5:0])) else $error("field bad");
   gain_on_a: assert property (
      cmp_dac_ref_on_o == (cmp_dac_ref_gain_o != 2'h0) &&
      converter_ref_on_o == (converter_ref_gain_o != 2'h0)) else $error("on bad");
   ready_drop_a: assert property (!ref_enable_o |=> !reference_ready_o)
      else $error("ready while off");
   ready_settle_a: assert property (
      $rose(ref_enable_o) |-> !reference_ready_o [*6]) else $error("ready early");
   route_a: assert property (temp_route_o ==
      $past(temp_indicator_enable_o && adc_channel_i == TEMP_CHANNEL))
      else $error("route bad");
   acq_select_a: assert property (
      $rose(temp_route_o) |-> ##2 !temp_acq_ok_o [*6]) else $error("acq early");
   acq_restart_a: assert property (
      adc_conv_start_i && temp_route_o |-> ##[1:2] !temp_acq_ok_o)
      else $error("acq kept");
endmodule : vref_ctrl_sva
bind vref_ctrl vref_ctrl_sva #(.TEMP_CHANNEL(TEMP_CHANNEL)) vref_ctrl_sva_inst (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_ack_o, .ref_enable_o, .reference_ready_o,
   .temp_indicator_enable_o, .temp_high_range_o, .cmp_dac_ref_gain_o,
   .cmp_dac_ref_on_o, .converter_ref_gain_o, .converter_ref_on_o,
   .adc_channel_i, .adc_conv_start_i, .temp_route_o, .temp_acq_ok_o);

// >>> verification/vref_ctrl_bench.sv
// Self-checking bench for the voltage reference control block
`timescale 1ns/100ps
module vref_ctrl_bench;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, adc_conv_start_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i, adc_channel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic ref_enable_o, reference_ready_o, temp_indicator_enable_o;
   logic temp_high_range_o, cmp_dac_ref_on_o, converter_ref_on_o;
   logic temp_route_o, temp_acq_ok_o;
   logic [1:0] cmp_dac_ref_gain_o, converter_ref_gain_o;
   int n_errors = 0;
   int tests_run = 0;
   // Rows: byte written, byte read back (status bit never sticks)
   logic [15:0] rows [4] = '{16'h3535, 16'h2a2a, 16'h1f1f, 16'h4000};
   // Short counts keep the run brief
   vref_ctrl #(.STAB_CYCLES(8), .TEMP_WAIT_CYCLES(20)) vref_ctrl_inst (
      .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .ref_enable_o, .reference_ready_o,
      .temp_indicator_enable_o, .temp_high_range_o, .cmp_dac_ref_gain_o,
      .cmp_dac_ref_on_o, .converter_ref_gain_o, .converter_ref_on_o,
      .adc_channel_i, .adc_conv_start_i, .temp_route_o, .temp_acq_ok_o);
   // Clock at 8 ns
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // One classic cycle; waits for ack without assuming latency
   task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <=
         {2'h3, we, a, d, s};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
   endtask : wb
   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask : chk
   task automatic final_report;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report
   // Hang guard, far beyond the hundred-odd cycles needed
   initial begin
      repeat (3000) @(posedge clk_i);
      n_errors++;
      final_report();
   end
   // Main sequence
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, adc_conv_start_i} = 5'h10;
      {wb_adr_i, wb_sel_i, wb_dat_i, adc_channel_i} = '0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, 8'h00, 0, 4'hf, rd);
      chk("ctrl_reset", 0, rd);
      foreach (rows[i]) begin
         wb(1, 8'h00, 32'(rows[i][15:8]), 4'hf, rd);
         @(posedge clk_i);
         chk("fields", 32'(rows[i][13:8]), 32'({temp_indicator_enable_o,
            temp_high_range_o, cmp_dac_ref_gain_o, converter_ref_gain_o}));
         chk("gain_on", 32'({|rows[i][11:10], |rows[i][9:8]}),
            32'({cmp_dac_ref_on_o, converter_ref_on_o}));
         wb(0, 8'h00, 0, 4'hf, rd);
         chk("ctrl_rd", 32'(rows[i][7:0]), rd);
      end
      // Unmapped place and a write without its byte lane
      wb(1, 8'h10, 32'h0000_00ff, 4'hf, rd);
      wb(0, 8'h10, 0, 4'hf, rd);
      chk("unmapped", 0, rd);
      wb(1, 8'h00, 32'h0000_0023, 4'he, rd);
      wb(0, 8'h00, 0, 4'hf, rd);
      chk("sel_off", 0, rd);
      // Reference settles, then drops when disabled
      wb(1, 8'h00, 32'h0000_0080, 4'hf, rd);
      @(posedge clk_i);
      chk("rdy_early", 0, 32'(reference_ready_o));
      for (int i = 0; i < 40 && reference_ready_o !== 1'b1; i++) @(posedge clk_i);
      wb(0, 8'h00, 0, 4'hf, rd);
      chk("rdy_rd", 32'h0000_00c0, rd);
      wb(1, 8'h00, 0, 4'hf, rd);
      repeat (2) @(posedge clk_i);
      chk("rdy_off", 0, 32'(reference_ready_o));
      // Indicator channel timing
      wb(1, 8'h00, 32'h0000_0020, 4'hf, rd);
      adc_channel_i <= 4'hd;
      repeat (3) @(posedge clk_i);
      chk("route", 32'h2, 32'({temp_route_o, temp_acq_ok_o}));
      repeat (25) @(posedge clk_i);
      chk("acq_ok", 1, 32'(temp_acq_ok_o));
      repeat (2) begin
         adc_conv_start_i <= 1'b1;
         @(posedge clk_i);
         adc_conv_start_i <= 1'b0;
         @(posedge clk_i);
         chk("acq_restart", 0, 32'(temp_acq_ok_o));
      end
      wb(0, 8'h04, 0, 4'hf, rd);
      chk("early_set", 32'h0000_0006, rd);
      wb(1, 8'h04, 32'h0000_0004, 4'hf, rd);
      wb(0, 8'h04, 0, 4'hf, rd);
      chk("early_clr", 32'h0000_0002, rd);
      adc_channel_i <= 4'h3;
      repeat (2) @(posedge clk_i);
      chk("route_off", 0, 32'(temp_route_o));
      // Mid-run reset must clear the enable written above
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, 8'h00, 0, 4'hf, rd);
      chk("ctrl_rst2", 0, rd);
      final_report();
   end
endmodule : vref_ctrl_bench
